// file: hdl/sdm_drive.v
// Purpose: Command-input logic of a two-phase microstepping drive.
// Assumes: Pins are asynchronous; register port on core_clk.
// Notes:   Release pin pulled low outside the block when left open.
//
// Behaviour
// R1: Active strobe edge commands one microstep.
// R2: Controller holds strobe pulse over 1.5 us.
// R3: Direction level chooses each microstep's sense. In double-pulse mode the code takes the sense from which pin pulsed instead.
// R4: Release asserted removes all phase current.
// R5: Release asserted ignores every strobe edge.
// R6: Unconnected release input reads as deasserted.
// R7: Current halves automatically when motor rests.
// R8: Resolution 200 to 51200 steps per revolution.
// R9: Up to 500 kHz; default limit 160 kHz.
// R10: Power-up tuning pass precedes normal stepping.
// R11: Over/undervoltage, overcurrent enter fault state.
// R12: Edge polarity and single/double pulse selectable.
// R13: Fault LED blinks code per 3 s cycle.
// R14: Position index counts up/down per step.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "sdm_map.vh"

module sdm_drive
#(
  parameter TUNE_CYC = `SDM_TUNE_CYC,     // Power-up tuning length
  parameter IDLE_CYC = `SDM_IDLE_CYC,     // Rest time before half current
  parameter SLOT_CYC = `SDM_LED_SLOT_CYC  // One LED blink slot
)
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Controller pins
  input  wire        step_strobe_input,
  input  wire        dir_level,
  input  wire        drive_release_input,
  // Supply and current monitors
  input  wire        over_volt,
  input  wire        under_volt,
  input  wire        over_cur,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Power stage commands
  output reg         phase_on,
  output reg         cur_half,
  output reg         step_pulse,
  output reg         step_up,
  output reg  [15:0] pos_idx,
  // Indicators
  output reg         fault_led,
  output reg         irq
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  wire [5:0] pins_s;  // Synchronised pin levels
  sdm_sync #(.W(6)) u_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   ({over_cur, under_volt, over_volt,
                drive_release_input, dir_level, step_strobe_input}),
    .pin_sync (pins_s)
  );
  wire stp_s = pins_s[0];
  wire dir_s = pins_s[1];
  wire rel_s = pins_s[2];  // R6
  wire ov_s  = pins_s[3];
  wire uv_s  = pins_s[4];
  wire oc_s  = pins_s[5];

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  reg  [4:0]  ctrl_r;      // Control bits
  reg  [15:0] res_r;       // Steps per revolution
  reg  [2:0]  stat_r;      // Sticky events
  reg  [2:0]  mask_r;      // Interrupt mask
  reg         stp_d_r;     // Previous strobe level
  reg         dir_d_r;     // Previous direction level
  reg  [15:0] gap_r;       // Cycles left before next step allowed
  reg         tuned_r;     // Tuning pass finished
  reg  [31:0] tune_cnt_r;  // Tuning timer
  reg  [31:0] idle_cnt_r;  // Time since last step
  reg         rest_r;      // Motor at rest
  reg  [1:0]  flt_r;       // Latched fault code
  reg  [31:0] slot_cnt_r;  // Position inside blink slot
  reg  [2:0]  slot_idx_r;  // Slot inside 3 s cycle

  wire edge_fall = ctrl_r[`SDM_CTRL_EDGE_FALL];
  wire dbl_mode  = ctrl_r[`SDM_CTRL_DBL_PULSE];
  wire rate_full = ctrl_r[`SDM_CTRL_RATE_FULL];
  wire half_en   = ctrl_r[`SDM_CTRL_HALF_EN];

  // ------------------------------------------------------------------
  // Edge detection and step acceptance
  // ------------------------------------------------------------------
  wire stp_edge = edge_fall ? (stp_d_r & ~stp_s)
                            : (stp_s & ~stp_d_r);  // R1 R12
  wire dir_edge = edge_fall ? (dir_d_r & ~dir_s)
                            : (dir_s & ~dir_d_r);  // R12
  wire step_req = stp_edge | (dbl_mode & dir_edge);
  // In double-pulse mode the strobe pin steps up, the other pin down
  wire go_up    = dbl_mode ? stp_edge : dir_s;     // R3
  wire fault_on = (flt_r != `SDM_FLT_NONE);
  wire run_ok   = tuned_r & ~rel_s & ~fault_on;    // R5 R10
  wire accept   = step_req & run_ok & (gap_r == 16'h0000);
  wire ignored  = step_req & ~accept;
  localparam [15:0] GAP_DEF = `SDM_GAP_DEF_CYC - 1;  // 160 kHz spacing
  localparam [15:0] GAP_MAX = `SDM_GAP_MAX_CYC - 1;  // 500 kHz spacing
  wire [15:0] gap_load = rate_full ? GAP_MAX : GAP_DEF;

  // Fault code by priority; overcurrent first
  wire [1:0] flt_now = oc_s ? `SDM_FLT_OC :
                       ov_s ? `SDM_FLT_OV :
                       uv_s ? `SDM_FLT_UV : `SDM_FLT_NONE;

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == `SDM_REG_CTRL);
  wire wr_res  = reg_wr & (reg_addr == `SDM_REG_RES);
  wire wr_pos  = reg_wr & (reg_addr == `SDM_REG_POS);
  wire wr_mask = reg_wr & (reg_addr == `SDM_REG_MASK);
  wire rd_stat = reg_rd & (reg_addr == `SDM_REG_STATUS);
  wire flt_clr = wr_ctrl & reg_wdata[`SDM_CTRL_FAULT_CLR];
  wire res_ok  = (reg_wdata[15:0] >= `SDM_RES_MIN) &
                 (reg_wdata[15:0] <= `SDM_RES_MAX);
  wire tune_end = ~tuned_r & (tune_cnt_r == TUNE_CYC - 1);

  // Control, resolution and mask; fault clear bit is a pulse only
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `SDM_CTRL_RST;
      res_r  <= `SDM_RES_RST;
      mask_r <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[4:0] & 5'h17;
      // Out-of-range resolution writes are dropped
      if (wr_res && res_ok)
        res_r <= reg_wdata[15:0];  // R8
      if (wr_mask)
        mask_r <= reg_wdata[2:0];
    end
  end

  // ------------------------------------------------------------------
  // Step timing, position index and direction
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stp_d_r    <= 1'b0;
      dir_d_r    <= 1'b0;
      gap_r      <= 16'h0000;
      pos_idx    <= 16'h0000;
      step_pulse <= 1'b0;
      step_up    <= 1'b0;
    end
    else
    begin
      stp_d_r    <= stp_s;
      dir_d_r    <= dir_s;
      step_pulse <= accept;  // R1
      // Minimum spacing enforces the selected rate ceiling
      if (accept)
        gap_r <= gap_load;  // R9
      else if (gap_r != 16'h0000)
        gap_r <= gap_r - 16'h0001;
      if (accept)
      begin
        step_up <= go_up;  // R3
        // Index wraps inside one revolution
        if (go_up)
          pos_idx <= (pos_idx >= res_r - 16'h0001) ? 16'h0000
                     : pos_idx + 16'h0001;  // R14 R8
        else
          pos_idx <= (pos_idx == 16'h0000 || pos_idx >= res_r)
                     ? res_r - 16'h0001 : pos_idx - 16'h0001;  // R14
      end
      else if (wr_pos)
        pos_idx <= reg_wdata[15:0];
    end
  end

  // ------------------------------------------------------------------
  // Power-up tuning pass
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tune_cnt_r <= 32'h0;
      tuned_r    <= 1'b0;
    end
    else if (!tuned_r)
    begin
      // Stepping stays locked out until the pass ends
      tune_cnt_r <= tune_cnt_r + 32'h1;  // R10
      if (tune_end)
        tuned_r <= 1'b1;  // R10
    end
  end

  // ------------------------------------------------------------------
  // Rest detection and phase current
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_cnt_r <= 32'h0;
      rest_r     <= 1'b0;
      phase_on   <= 1'b0;
      cur_half   <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        idle_cnt_r <= 32'h0;
        rest_r     <= 1'b0;
      end
      else if (idle_cnt_r == IDLE_CYC - 1)
        rest_r <= 1'b1;  // R7
      else
        idle_cnt_r <= idle_cnt_r + 32'h1;
      // Release or fault frees the shaft
      phase_on <= tuned_r & ~rel_s & ~fault_on;  // R4 R11
      cur_half <= half_en & rest_r & ~accept &
                  tuned_r & ~rel_s & ~fault_on;  // R7
    end
  end

  // ------------------------------------------------------------------
  // Fault latch
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      flt_r <= `SDM_FLT_NONE;
    else if (flt_now != `SDM_FLT_NONE && (!fault_on || flt_now < flt_r))
      flt_r <= flt_now;  // R11
    else if (flt_clr && flt_now == `SDM_FLT_NONE)
      // Clear only once every monitor reads healthy
      flt_r <= `SDM_FLT_NONE;
  end

  // ------------------------------------------------------------------
  // Fault LED blink code
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_cnt_r <= 32'h0;
      slot_idx_r <= 3'h0;
      fault_led  <= 1'b0;
    end
    else if (!fault_on)
    begin
      // Restart the pattern so each fault opens with a blink
      slot_cnt_r <= 32'h0;
      slot_idx_r <= 3'h0;
      fault_led  <= 1'b0;  // R13
    end
    else
    begin
      if (slot_cnt_r == SLOT_CYC - 1)
      begin
        slot_cnt_r <= 32'h0;
        slot_idx_r <= (slot_idx_r == `SDM_LED_SLOTS - 1) ? 3'h0
                      : slot_idx_r + 3'h1;  // R13
      end
      else
        slot_cnt_r <= slot_cnt_r + 32'h1;
      // On for the first half of each of the first code slots
      fault_led <= (slot_idx_r < {1'b0, flt_r}) &
                   (slot_cnt_r < SLOT_CYC / 2);  // R13
    end
  end

  // ------------------------------------------------------------------
  // Sticky status, read clears; set wins over clear
  // ------------------------------------------------------------------
  wire [2:0] ev = {ignored, (flt_now != `SDM_FLT_NONE) & ~fault_on,
                   tune_end};

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_r <= 3'h0;
      irq    <= 1'b0;
    end
    else
    begin
      stat_r <= (rd_stat ? 3'h0 : stat_r) | ev;
      irq    <= |(((rd_stat ? 3'h0 : stat_r) | ev) & mask_r);
    end
  end

  // ------------------------------------------------------------------
  // Register read, data in the cycle after the strobe
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SDM_REG_CTRL:   reg_rdata <= {27'h0, ctrl_r};
        `SDM_REG_RES:    reg_rdata <= {16'h0, res_r};
        `SDM_REG_POS:    reg_rdata <= {16'h0, pos_idx};
        `SDM_REG_STATUS: reg_rdata <= {29'h0, stat_r};
        `SDM_REG_MASK:   reg_rdata <= {29'h0, mask_r};
        `SDM_REG_STATE:  reg_rdata <= {24'h0, flt_r, rel_s, rest_r,
                                       cur_half, phase_on, tuned_r,
                                       step_up};
        default:         reg_rdata <= 32'h0;  // Unmapped reads zero
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

endmodule

// file: pkg/sdm_map.vh
// Purpose: Register map, field positions, reset values and timing counts
//          of the step/direction drive input block.
// Assumes: 200 MHz core clock.
// Notes:   Definitions only; included by bare name.
`ifndef SDM_MAP_VH
`define SDM_MAP_VH

// ------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ------------------------------------------------------------------
`define SDM_REG_CTRL      8'h00
`define SDM_REG_RES       8'h04
`define SDM_REG_POS       8'h08
`define SDM_REG_STATUS    8'h0c
`define SDM_REG_MASK      8'h10
`define SDM_REG_STATE     8'h14

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define SDM_CTRL_EDGE_FALL 0
`define SDM_CTRL_DBL_PULSE 1
`define SDM_CTRL_RATE_FULL 2
`define SDM_CTRL_FAULT_CLR 3
`define SDM_CTRL_HALF_EN   4
`define SDM_CTRL_RST       5'h10

// ------------------------------------------------------------------
// Status / mask fields
// ------------------------------------------------------------------
`define SDM_ST_TUNED      0
`define SDM_ST_FAULT      1
`define SDM_ST_IGNORED    2

// ------------------------------------------------------------------
// Resolution limits and reset value
// ------------------------------------------------------------------
`define SDM_RES_MIN       16'd200
`define SDM_RES_MAX       16'd51200
`define SDM_RES_RST       16'd200

// ------------------------------------------------------------------
// Fault codes (blink counts, lower is higher priority)
// ------------------------------------------------------------------
`define SDM_FLT_NONE      2'd0
`define SDM_FLT_OC        2'd1
`define SDM_FLT_OV        2'd2
`define SDM_FLT_UV        2'd3

// ------------------------------------------------------------------
// Timing: figures in their own units, cycle counts derived
// ------------------------------------------------------------------
`define SDM_CLK_MHZ       200
`define SDM_RATE_DEF_KHZ  160
`define SDM_RATE_MAX_KHZ  500
`define SDM_GAP_DEF_CYC   \
  ((`SDM_CLK_MHZ*1000+`SDM_RATE_DEF_KHZ-1)/`SDM_RATE_DEF_KHZ)
`define SDM_GAP_MAX_CYC   \
  ((`SDM_CLK_MHZ*1000+`SDM_RATE_MAX_KHZ-1)/`SDM_RATE_MAX_KHZ)
`define SDM_TUNE_MS       100
`define SDM_TUNE_CYC      (`SDM_TUNE_MS*`SDM_CLK_MHZ*1000)
`define SDM_IDLE_MS       500
`define SDM_IDLE_CYC      (`SDM_IDLE_MS*`SDM_CLK_MHZ*1000)
`define SDM_LED_CYCLE_MS  3000
`define SDM_LED_SLOTS     6
`define SDM_LED_SLOT_CYC  (`SDM_LED_CYCLE_MS*`SDM_CLK_MHZ*1000/`SDM_LED_SLOTS)

`endif

// file: hdl/sdm_sync.v
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to core_clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps

module sdm_sync
#(
  parameter W = 1
)
(
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_b,
  // Levels
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);

  reg [W-1:0] meta_r;  // First stage, read only by second

  // ------------------------------------------------------------------
  // Two flip-flops per bit
  // ------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r   <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end
    else
    begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule

// file: test/sdm_drive_sva.sv
// Purpose: Port checks of the drive input block.
// Assumes: One clock domain, rst_b async active low.
// Notes:   Bound to sdm_drive below.
`timescale 1ns/100ps

module sdm_drive_sva
#(
  parameter TUNE_CYC = 20,
  parameter IDLE_CYC = 50
)
(
  // Clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // Pins and monitors
  input wire        drive_release_input,
  input wire        over_volt,
  input wire        under_volt,
  input wire        over_cur,
  // Register port
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // Drive outputs
  input wire        phase_on,
  input wire        cur_half,
  input wire        step_pulse,
  input wire        step_up,
  input wire [15:0] pos_idx
);
  reg [31:0] tune_cnt_r; // Cycles since reset release
  reg [15:0] gap_cnt_r;  // Cycles since last step
  reg        seen_r;     // A step was seen

  // Saturating, so a long rest never wraps
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tune_cnt_r <= 32'h0;
      gap_cnt_r  <= 16'h0;
      seen_r     <= 1'b0;
    end
    else
    begin
      if (tune_cnt_r != 32'hffffffff)
        tune_cnt_r <= tune_cnt_r + 32'h1;
      if (step_pulse)
        gap_cnt_r <= 16'h0;
      else if (gap_cnt_r != 16'hffff)
        gap_cnt_r <= gap_cnt_r + 16'h1;
      seen_r <= seen_r | step_pulse;
    end
  end

  property p_once;
    @(posedge core_clk) disable iff (!rst_b)
    step_pulse |=> !step_pulse;
  endproperty
  a_once: assert property (p_once) else $error("long step");
  property p_gap;
    @(posedge core_clk) disable iff (!rst_b)
    step_pulse && seen_r |-> gap_cnt_r >= 16'd399;
  endproperty
  a_gap: assert property (p_gap) else $error("steps close");
  property p_tune;
    @(posedge core_clk) disable iff (!rst_b)
    step_pulse |-> tune_cnt_r >= TUNE_CYC;
  endproperty
  a_tune: assert property (p_tune) else $error("early step");
  property p_free;
    @(posedge core_clk) disable iff (!rst_b)
    drive_release_input [*4] |-> !phase_on;
  endproperty
  a_free: assert property (p_free) else $error("current on");
  property p_ign;
    @(posedge core_clk) disable iff (!rst_b)
    drive_release_input [*6] |-> !step_pulse;
  endproperty
  a_ign: assert property (p_ign) else $error("step taken");
  property p_flt;
    @(posedge core_clk) disable iff (!rst_b)
    (over_cur || over_volt || under_volt) [*5] |-> !phase_on;
  endproperty
  a_flt: assert property (p_flt) else $error("no fault");
  property p_idx;
    @(posedge core_clk) disable iff (!rst_b)
    step_pulse && pos_idx != 16'h0 && $past(pos_idx) != 16'h0 |->
      pos_idx == (step_up ? $past(pos_idx) + 16'h1
                          : $past(pos_idx) - 16'h1);
  endproperty
  a_idx: assert property (p_idx) else $error("bad index");
  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !step_pulse && !$past(reg_wr) |-> $stable(pos_idx);
  endproperty
  a_hold: assert property (p_hold) else $error("index moved");
  property p_rest;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(cur_half) |-> gap_cnt_r >= IDLE_CYC - 1;
  endproperty
  a_rest: assert property (p_rest) else $error("early half");
  property p_rd;
    @(posedge core_clk) disable iff (!rst_b)
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("stray data");
endmodule

bind sdm_drive sdm_drive_sva
#(
  .TUNE_CYC(TUNE_CYC),
  .IDLE_CYC(IDLE_CYC)
)
sdm_drive_sva_inst
(
  .core_clk(core_clk), .rst_b(rst_b),
  .drive_release_input(drive_release_input),
  .over_volt(over_volt), .under_volt(under_volt), .over_cur(over_cur),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .phase_on(phase_on), .cur_half(cur_half), .step_pulse(step_pulse),
  .step_up(step_up), .pos_idx(pos_idx)
);

// file: test/sdm_ctl_model.sv
// Purpose: Motion controller driving strobe and direction pins.
// Assumes: Pins change just after a rising core_clk edge.
// Notes:   Pulse width is set by the caller.
`timescale 1ns/100ps

module sdm_ctl_model
(
  // Clock
  input wire core_clk,
  // Controller pins
  output reg step_strobe_input,
  output reg dir_level
);
  // Both lines idle low
  initial
  begin
    step_strobe_input = 1'b0;
    dir_level         = 1'b0;
  end

  // One pulse on the strobe line or on the direction line
  task pulse(input logic on_dir, input logic up, input int width);
    begin
      @(posedge core_clk);
      if (!on_dir)
        dir_level <= up;
      // Direction settles well before the strobe
      repeat (8) @(posedge core_clk);
      if (on_dir)
        dir_level <= 1'b1;
      else
        step_strobe_input <= 1'b1;
      repeat (width) @(posedge core_clk);
      if (on_dir)
        dir_level <= 1'b0;
      else
        step_strobe_input <= 1'b0;
    end
  endtask
endmodule

// file: test/sdm_drive_test.sv
// Purpose: Register and pin level tests of sdm_drive.
// Assumes: 200 MHz clock; short tuning, rest and LED counts.
// Notes:   Strobes kept 320 cycles wide.
`timescale 1ns/100ps
`include "sdm_map.vh"

module sdm_drive_test;
  reg         core_clk, rst_b, drive_release_input;
  reg         over_volt, under_volt, over_cur;
  reg         reg_wr, reg_rd, stb_at, prev;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata, d;
  wire [31:0] reg_rdata;
  wire        step_strobe_input, dir_level, phase_on, cur_half;
  wire        step_pulse, step_up, fault_led, irq;
  wire [15:0] pos_idx;
  int         fails, tests_run, nsteps, n, k;

  sdm_drive #(.TUNE_CYC(20), .IDLE_CYC(50), .SLOT_CYC(16)) sdm_drive_inst (
    .core_clk(core_clk), .rst_b(rst_b),
    .step_strobe_input(step_strobe_input), .dir_level(dir_level),
    .drive_release_input(drive_release_input),
    .over_volt(over_volt), .under_volt(under_volt), .over_cur(over_cur),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_on(phase_on),
    .cur_half(cur_half), .step_pulse(step_pulse), .step_up(step_up),
    .pos_idx(pos_idx), .fault_led(fault_led), .irq(irq));
  sdm_ctl_model sdm_ctl_model_inst (.core_clk(core_clk),
    .step_strobe_input(step_strobe_input), .dir_level(dir_level));

  always #2.5 core_clk = ~core_clk;

  // Count steps; keep the strobe level seen at each
  always @(posedge core_clk)
    if (step_pulse === 1'b1)
    begin
      nsteps = nsteps + 1;
      stb_at <= step_strobe_input;
    end

  task report_and_stop;
    begin
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Data is registered at the taking edge, read just after it
  task rd(input logic [7:0] a, output logic [31:0] v);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask

  task step(input logic on_dir, input logic up, input int after);
    begin
      sdm_ctl_model_inst.pulse(on_dir, up, 320);
      repeat (after) @(posedge core_clk);
    end
  endtask

  // Rising LED edges over one 3 s cycle of 6 slots
  task led(output int c);
    begin
      c = 0;
      prev = fault_led;
      repeat (96)
      begin
        @(posedge core_clk);
        #1 if (fault_led === 1'b1 && prev !== 1'b1)
          c = c + 1;
        prev = fault_led;
      end
    end
  endtask

  initial
  begin
    #450000;
    fails = fails + 1;
    report_and_stop;
  end

  initial
  begin
    {core_clk, rst_b, drive_release_input, reg_wr, reg_rd} = 5'h0;
    {over_volt, under_volt, over_cur, stb_at} = 4'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    {fails, tests_run, nsteps} = {32'd0, 32'd0, 32'd0};
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`SDM_REG_CTRL, d); chk(d, 32'h10);
    rd(`SDM_REG_RES, d); chk(d, 32'd200);
    rd(`SDM_REG_MASK, d); chk(d, 32'h0);
    rd(8'h20, d); chk(d, 32'h0);
    repeat (30) @(posedge core_clk);
    rd(`SDM_REG_STATUS, d); chk(d, 32'h1);
    chk(phase_on, 1);
    wr(`SDM_REG_MASK, 32'h7);
    step(0, 1, 1000); chk(pos_idx, 1);
    chk(step_up, 1); chk(stb_at, 1);
    step(0, 0, 1000); chk(pos_idx, 0);
    step(0, 0, 1000); chk(pos_idx, 199);
    wr(`SDM_REG_RES, 32'd51201);
    rd(`SDM_REG_RES, d); chk(d, 32'd200);
    wr(`SDM_REG_RES, 32'd51200);
    rd(`SDM_REG_RES, d); chk(d, 32'd51200);
    wr(`SDM_REG_POS, 32'd51199);
    step(0, 1, 1000); chk(pos_idx, 0);
    step(0, 1, 300);
    step(0, 1, 1300); chk(pos_idx, 1); chk(irq, 1);
    rd(`SDM_REG_STATUS, d); chk(d, 32'h4);
    repeat (2) @(posedge core_clk);
    chk(irq, 0);
    wr(`SDM_REG_CTRL, 32'h14);
    step(0, 1, 300);
    step(0, 1, 1000); chk(pos_idx, 3);
    chk(cur_half, 1);
    wr(`SDM_REG_CTRL, 32'h15);
    step(0, 0, 10); chk(cur_half, 0);
    chk(pos_idx, 2); chk(stb_at, 0);
    repeat (1000) @(posedge core_clk);
    wr(`SDM_REG_CTRL, 32'h16);
    step(1, 0, 1000); chk(pos_idx, 1);
    step(0, 0, 1000); chk(pos_idx, 2);
    wr(`SDM_REG_CTRL, 32'h14);
    @(posedge core_clk);
    drive_release_input <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(phase_on, 0);
    step(0, 1, 1000); chk(pos_idx, 2); chk(nsteps, 10);
    drive_release_input <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(phase_on, 1);
    rd(`SDM_REG_STATUS, d);
    for (k = 0; k < 3; k = k + 1)
    begin
      @(posedge core_clk);
      {over_cur, over_volt, under_volt} <= 3'h4 >> k;
      repeat (5) @(posedge core_clk);
      chk(phase_on, 0); chk(irq, 1);
      rd(`SDM_REG_STATE, d); chk(d[7:6], k + 1);
      led(n); chk(n, k + 1);
      @(posedge core_clk);
      {over_cur, over_volt, under_volt} <= 3'h0;
      // Clear only once the synchronised monitors read healthy
      repeat (2) @(posedge core_clk);
      wr(`SDM_REG_CTRL, 32'h1c);
      repeat (5) @(posedge core_clk);
      chk(phase_on, 1);
      led(n); chk(n, 0);
      rd(`SDM_REG_STATUS, d); chk(d, 32'h2);
    end
    report_and_stop;
  end
endmodule
